//--- odc_dbnc.sv
// Debounce engine that accepts a new orientation once it has persisted for one step more than the programmed count.
`timescale 1ns/10ps
module odc_dbnc
  import odc_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  // Control and status
  odc_dbnc_if.eng dif
);

  odc_state_t st_ff;
  logic [7:0] cnt_ff;
  odc_orient_t state_ff;
  logic changed_ff;
  logic step;

  assign step = dif.tick && !dif.hold;
  assign dif.state = state_ff;
  assign dif.changed = changed_ff;

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_ff <= ODC_ST_OFF;
    end else begin
      case (st_ff)
        ODC_ST_OFF: begin
          if (dif.enable) begin
            st_ff <= ODC_ST_FIRST;
          end
        end
        ODC_ST_FIRST: begin
          if (!dif.enable) begin
            st_ff <= ODC_ST_OFF;
          end else if (step) begin
            st_ff <= ODC_ST_TRACK;
          end
        end
        ODC_ST_TRACK: begin
          if (!dif.enable) begin
            st_ff <= ODC_ST_OFF;
          end
        end
        default: begin
          st_ff <= ODC_ST_OFF;
        end
      endcase
    end
  end

  // The counter only counts on steps, so its weight follows the selected time step.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cnt_ff <= 8'h00;
    end else if (dif.restart || st_ff != ODC_ST_TRACK) begin
      cnt_ff <= 8'h00;
    end else if (step) begin
      if (dif.cand != state_ff) begin
        cnt_ff <= (cnt_ff >= dif.limit) ? 8'h00 : cnt_ff + 8'h01;
      end else if (dif.dec_mode) begin
        cnt_ff <= (cnt_ff != 8'h00) ? cnt_ff - 8'h01 : 8'h00;
      end else begin
        cnt_ff <= 8'h00;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_ff <= '0;
      changed_ff <= 1'b0;
    end else begin
      changed_ff <= 1'b0;
      if (st_ff == ODC_ST_FIRST && dif.enable && step) begin
        state_ff <= dif.cand;
        changed_ff <= 1'b1;
      end else if (st_ff == ODC_ST_TRACK && dif.enable && step && !dif.restart && dif.cand != state_ff &&
                   cnt_ff >= dif.limit) begin
        state_ff <= dif.cand;
        changed_ff <= 1'b1;
      end
    end
  end

  a_restart_clears: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    dif.restart |=> cnt_ff == 8'h00)
    else $error("debounce counter not cleared by wake/sleep change");
  a_hold_freezes: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    dif.hold |=> $stable(state_ff))
    else $error("orientation changed while over-range hold active");
  a_accept_at_limit: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (st_ff == ODC_ST_TRACK && $past(st_ff) == ODC_ST_TRACK && $changed(state_ff)) |->
    $past(cnt_ff) >= $past(dif.limit))
    else $error("orientation accepted before debounce count reached");
  a_clear_mode: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (st_ff == ODC_ST_TRACK && step && !dif.dec_mode && dif.cand == state_ff) |=> cnt_ff == 8'h00)
    else $error("clear mode did not clear counter");
  a_dec_mode: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (st_ff == ODC_ST_TRACK && step && !dif.restart && dif.enable && dif.dec_mode && dif.cand == state_ff &&
     cnt_ff != 8'h00) |=> cnt_ff == $past(cnt_ff) - 8'h01)
    else $error("decrement mode did not step counter down");

endmodule : odc_dbnc

//--- odc_dbnc_if.sv
// Signals between the orientation top and its debounce engine.
`timescale 1ns/10ps
interface odc_dbnc_if;
  import odc_pkg::*;
  logic tick;
  logic restart;
  logic enable;
  logic hold;
  logic dec_mode;
  logic [7:0] limit;
  odc_orient_t cand;
  odc_orient_t state;
  logic changed;

  modport ctl (output tick, restart, enable, hold, dec_mode, limit, cand, input state, changed);
  modport eng (input tick, restart, enable, hold, dec_mode, limit, cand, output state, changed);
endinterface : odc_dbnc_if

//--- odc_defs.svh
// Register offsets, field positions, reset values and timing counts of the orientation block.
`ifndef ODC_DEFS_SVH
`define ODC_DEFS_SVH

`define ODC_ADDR_STATUS 8'h10
`define ODC_ADDR_CFG 8'h11
`define ODC_ADDR_DBNC 8'h12
`define ODC_ADDR_BFZ 8'h13
`define ODC_ADDR_THS 8'h14

`define ODC_CFG_DBMODE_BIT 7
`define ODC_CFG_EN_BIT 6
`define ODC_BFZ_BACK_FRONT_TRIP_SEL_HI 7
`define ODC_BFZ_BACK_FRONT_TRIP_SEL_LO 6
`define ODC_BFZ_Z_LOCKOUT_ANGLE_SEL_HI 2
`define ODC_BFZ_Z_LOCKOUT_ANGLE_SEL_LO 0
`define ODC_THS_THR_HI 7
`define ODC_THS_THR_LO 3
`define ODC_THS_HYS_HI 2
`define ODC_THS_HYS_LO 0

`define ODC_RST_CFG 8'h00
`define ODC_RST_DBNC 8'h00
`define ODC_RST_BFZ 8'h44
`define ODC_RST_THS 8'h84

`define ODC_CLK_MHZ 250
`define ODC_STEP_800_US 1250
`define ODC_STEP_400_US 2500
`define ODC_STEP_200_US 5000
`define ODC_STEP_100_US 10000
`define ODC_STEP_50_US 20000
`define ODC_STEP_LOW_US 80000
`define ODC_STEP_SLOW_US 160000
`define ODC_US_TO_CYC(us) ((us) * `ODC_CLK_MHZ)

`endif

//--- odc_host.sv
// Host model that configures the orientation block over its register port.
`timescale 1ns/10ps
`include "odc_defs.svh"
module odc_host (
  // Clock
  input wire logic i_clk,
  // Register port
  output logic [7:0] o_addr,
  output logic o_wr,
  output logic [7:0] o_wdata,
  output logic o_rd,
  input wire logic [7:0] i_rdata
);
  initial begin
    o_addr = 8'h00;
    o_wr = 1'b0;
    o_wdata = 8'h00;
    o_rd = 1'b0;
  end

  // A threshold plus hysteresis above 31 is never sent; the hysteresis drops to zero instead.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    int s;
    s = d[7:3] + d[2:0];
    if (a == `ODC_ADDR_THS && (s == 0 || s > 31)) d[2:0] = 3'h0;
    @(negedge i_clk);
    o_addr = a;
    o_wdata = d;
    o_wr = 1'b1;
    @(negedge i_clk);
    o_wr = 1'b0;
    o_wdata = ~d;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge i_clk);
    o_addr = a;
    o_rd = 1'b1;
    @(negedge i_clk);
    o_rd = 1'b0;
    @(negedge i_clk);
    d = i_rdata;
  endtask : rd
endmodule : odc_host

//--- odc_pkg.sv
// Types shared by the orientation configuration and debounce logic.
package odc_pkg;

  typedef enum logic [2:0] {
    ODC_ST_OFF = 3'b001,
    ODC_ST_FIRST = 3'b010,
    ODC_ST_TRACK = 3'b100
  } odc_state_t;

  typedef enum logic [1:0] {
    ODC_OS_NORMAL = 2'h0,
    ODC_OS_LOW_NOISE_LOW_POWER_OVERSAMPLING = 2'h1,
    ODC_OS_HIRES = 2'h2,
    ODC_OS_LP = 2'h3
  } odc_os_mode_t;

  // Orientation word: lockout, landscape/portrait code, back flag.
  typedef struct packed {
    logic lockout;
    logic [1:0] lapo;
    logic back;
  } odc_orient_t;

endpackage : odc_pkg

//--- odc_top.sv
// Orientation detector configuration registers, angle decode, time-step divider and status.
`timescale 1ns/10ps
`include "odc_defs.svh"
module odc_top
  import odc_pkg::*;
#(
  parameter int unsigned STEP_800_CYC = `ODC_US_TO_CYC(`ODC_STEP_800_US),
  parameter int unsigned STEP_400_CYC = `ODC_US_TO_CYC(`ODC_STEP_400_US),
  parameter int unsigned STEP_200_CYC = `ODC_US_TO_CYC(`ODC_STEP_200_US),
  parameter int unsigned STEP_100_CYC = `ODC_US_TO_CYC(`ODC_STEP_100_US),
  parameter int unsigned STEP_50_CYC = `ODC_US_TO_CYC(`ODC_STEP_50_US),
  parameter int unsigned STEP_LOW_CYC = `ODC_US_TO_CYC(`ODC_STEP_LOW_US),
  parameter int unsigned STEP_SLOW_CYC = `ODC_US_TO_CYC(`ODC_STEP_SLOW_US)
) (
  // Clock and reset
  input wire logic I_CLK_SYS,
  input wire logic I_ARST_N,
  // Register port
  input wire logic [7:0] I_REG_ADDR,
  input wire logic I_REG_WR,
  input wire logic [7:0] I_REG_WDATA,
  input wire logic I_REG_RD,
  output logic [7:0] O_REG_RDATA,
  // System mode
  input wire logic I_ACTIVE,
  input wire logic I_SLEEP,
  input wire logic [2:0] I_OUTPUT_SAMPLE_RATE,
  input wire logic [1:0] I_OVERSAMPLING_MODE,
  // Measured angles, degrees
  input wire logic [8:0] I_Z_ANGLE,
  input wire logic [6:0] I_Z_TILT,
  input wire logic [6:0] I_PL_ANGLE,
  input wire logic I_Y_NEG,
  input wire logic I_X_NEG,
  input wire logic I_OVER_RANGE,
  // Orientation outputs
  output logic [7:0] O_ORIENT_STATUS,
  output logic O_ORIENT_CHANGE_FLAG
);

  localparam logic [7:0] THR_DEG [0:31] = '{8'h00, 8'h02, 8'h04, 8'h06, 8'h08, 8'h0A, 8'h0D, 8'h0F,
    8'h11, 8'h14, 8'h18, 8'h1B, 8'h1E, 8'h23, 8'h25, 8'h28, 8'h2D, 8'h30, 8'h34, 8'h37, 8'h3C,
    8'h3F, 8'h43, 8'h46, 8'h48, 8'h4B, 8'h4D, 8'h4F, 8'h51, 8'h54, 8'h57, 8'h5A};
  localparam logic [7:0] HYS_DEG [0:7] = '{8'h00, 8'h04, 8'h07, 8'h0B, 8'h0E, 8'h11, 8'h15, 8'h18};
  localparam logic [7:0] ZLK_DEG [0:7] = '{8'h0E, 8'h12, 8'h15, 8'h19, 8'h1D, 8'h21, 8'h25, 8'h2A};
  localparam logic [8:0] BACK_LO_BASE = 9'h050;
  localparam logic [8:0] BACK_HI_BASE = 9'h118;
  localparam logic [8:0] FRONT_LO_BASE = 9'h064;
  localparam logic [8:0] FRONT_HI_BASE = 9'h104;
  localparam logic [8:0] BACK_FRONT_TRIP_SEL_STEP = 9'h005;

  logic [7:0] cfg_ff;
  logic [7:0] dbnc_ff;
  logic [7:0] bfz_ff;
  logic [7:0] ths_ff;
  logic [7:0] rdata_ff;
  logic flag_ff;
  logic sleep_ff;
  logic [27:0] div_ff;
  logic tick_ff;
  logic [27:0] step_cyc;
  logic [8:0] bk_off;
  logic [7:0] trip_deg;
  logic [7:0] hys_deg;
  logic portrait;
  odc_orient_t cand;
  logic stat_rd;

  odc_dbnc_if dif ();

  odc_dbnc u_dbnc (
    .i_clk(I_CLK_SYS),
    .i_arst_n(I_ARST_N),
    .dif(dif)
  );

  // Time step in clock cycles for a rate code and oversampling mode.
  function automatic logic [27:0] step_for(input logic [2:0] rate, input logic [1:0] mode);
    logic [27:0] cyc;
    cyc = 28'(STEP_50_CYC);
    case (rate)
      3'h0: cyc = 28'(STEP_800_CYC);
      3'h1: cyc = 28'(STEP_400_CYC);
      default: begin
        if (mode == ODC_OS_HIRES) begin
          cyc = 28'(STEP_400_CYC);
        end else if (rate == 3'h2) begin
          cyc = 28'(STEP_200_CYC);
        end else if (rate == 3'h3) begin
          cyc = 28'(STEP_100_CYC);
        end else if (rate == 3'h4 || mode == ODC_OS_NORMAL) begin
          cyc = 28'(STEP_50_CYC);
        end else if (rate == 3'h5 || mode == ODC_OS_LOW_NOISE_LOW_POWER_OVERSAMPLING) begin
          cyc = 28'(STEP_LOW_CYC);
        end else begin
          cyc = 28'(STEP_SLOW_CYC);
        end
      end
    endcase
    return cyc;
  endfunction : step_for

  assign stat_rd = I_REG_RD && I_REG_ADDR == `ODC_ADDR_STATUS;
  assign step_cyc = step_for(I_OUTPUT_SAMPLE_RATE, I_OVERSAMPLING_MODE);

  // Register writes; all bits are stored, don't-care bits feed no logic.
  always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      cfg_ff <= `ODC_RST_CFG;
      dbnc_ff <= `ODC_RST_DBNC;
      bfz_ff <= `ODC_RST_BFZ;
      ths_ff <= `ODC_RST_THS;
    end else if (I_REG_WR) begin
      case (I_REG_ADDR)
        `ODC_ADDR_CFG: cfg_ff <= I_REG_WDATA;
        `ODC_ADDR_DBNC: dbnc_ff <= I_REG_WDATA;
        `ODC_ADDR_BFZ: bfz_ff <= I_REG_WDATA;
        `ODC_ADDR_THS: ths_ff <= I_REG_WDATA;
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      rdata_ff <= 8'h00;
    end else if (I_REG_RD) begin
      case (I_REG_ADDR)
        `ODC_ADDR_STATUS: rdata_ff <= O_ORIENT_STATUS;
        `ODC_ADDR_CFG: rdata_ff <= cfg_ff;
        `ODC_ADDR_DBNC: rdata_ff <= dbnc_ff;
        `ODC_ADDR_BFZ: rdata_ff <= bfz_ff;
        `ODC_ADDR_THS: rdata_ff <= ths_ff;
        default: rdata_ff <= 8'h00;
      endcase
    end
  end

  // Step divider wraps with a tick as soon as its count reaches one less than the period picked by the rate and mode.
  always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      div_ff <= 28'h0000000;
      tick_ff <= 1'b0;
    end else if (div_ff + 28'h0000001 >= step_cyc) begin
      div_ff <= 28'h0000000;
      tick_ff <= 1'b1;
    end else begin
      div_ff <= div_ff + 28'h0000001;
      tick_ff <= 1'b0;
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      sleep_ff <= 1'b0;
    end else begin
      sleep_ff <= I_SLEEP;
    end
  end

  // Angle decode of the candidate orientation.
  always_comb begin
    bk_off = 9'(bfz_ff[`ODC_BFZ_BACK_FRONT_TRIP_SEL_HI:`ODC_BFZ_BACK_FRONT_TRIP_SEL_LO]) * BACK_FRONT_TRIP_SEL_STEP;
    trip_deg = THR_DEG[ths_ff[`ODC_THS_THR_HI:`ODC_THS_THR_LO]];
    hys_deg = HYS_DEG[ths_ff[`ODC_THS_HYS_HI:`ODC_THS_HYS_LO]];
    portrait = (dif.state.lapo[1] == 1'b0);
    if (portrait) begin
      portrait = {1'b0, I_PL_ANGLE} + hys_deg >= trip_deg;
    end else begin
      portrait = {1'b0, I_PL_ANGLE} > trip_deg + hys_deg;
    end
    cand.lapo = portrait ? {1'b0, I_Y_NEG} : {1'b1, I_X_NEG};
    cand.lockout = {1'b0, I_Z_TILT} < ZLK_DEG[bfz_ff[`ODC_BFZ_Z_LOCKOUT_ANGLE_SEL_HI:`ODC_BFZ_Z_LOCKOUT_ANGLE_SEL_LO]];
    if (I_Z_ANGLE < BACK_LO_BASE - bk_off || I_Z_ANGLE > BACK_HI_BASE + bk_off) begin
      cand.back = 1'b1;
    end else if (I_Z_ANGLE > FRONT_LO_BASE + bk_off && I_Z_ANGLE < FRONT_HI_BASE - bk_off) begin
      cand.back = 1'b0;
    end else begin
      cand.back = dif.state.back;
    end
  end

  assign dif.tick = tick_ff;
  assign dif.restart = sleep_ff != I_SLEEP;
  assign dif.enable = cfg_ff[`ODC_CFG_EN_BIT] && I_ACTIVE;
  assign dif.hold = I_OVER_RANGE;
  assign dif.dec_mode = cfg_ff[`ODC_CFG_DBMODE_BIT];
  assign dif.limit = dbnc_ff;
  assign dif.cand = cand;

  // A new change in the read cycle wins over the clear.
  always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      flag_ff <= 1'b0;
    end else if (dif.changed) begin
      flag_ff <= 1'b1;
    end else if (stat_rd) begin
      flag_ff <= 1'b0;
    end
  end

  assign O_REG_RDATA = rdata_ff;
  assign O_ORIENT_CHANGE_FLAG = flag_ff;
  assign O_ORIENT_STATUS = {flag_ff, dif.state.lockout, 3'b000, dif.state.lapo, dif.state.back};

  a_flag_set_wins: assert property (@(posedge I_CLK_SYS) disable iff (!I_ARST_N)
    dif.changed |=> flag_ff)
    else $error("change flag not set after orientation change");
  a_flag_read_clr: assert property (@(posedge I_CLK_SYS) disable iff (!I_ARST_N)
    (stat_rd && !dif.changed) |=> !flag_ff)
    else $error("status read did not clear change flag");
  a_disabled_quiet: assert property (@(posedge I_CLK_SYS) disable iff (!I_ARST_N)
    !cfg_ff[`ODC_CFG_EN_BIT] [*2] |-> !dif.changed)
    else $error("orientation change reported while disabled");
  a_tick_spacing: assert property (@(posedge I_CLK_SYS) disable iff (!I_ARST_N)
    (step_cyc == 28'(STEP_800_CYC) && $stable(step_cyc) && div_ff == 28'(STEP_800_CYC) - 28'h0000001) |=>
    (tick_ff && div_ff == 28'h0000000))
    else $error("step tick missing at 800 Hz period");
  a_hires_step: assert property (@(posedge I_CLK_SYS) disable iff (!I_ARST_N)
    (I_OVERSAMPLING_MODE == ODC_OS_HIRES && I_OUTPUT_SAMPLE_RATE != 3'h0) |-> step_cyc == 28'(STEP_400_CYC))
    else $error("high resolution step not held at 2.5 ms");
  a_status_layout: assert property (@(posedge I_CLK_SYS) disable iff (!I_ARST_N)
    $rose(stat_rd) |=> O_REG_RDATA[7] == $past(flag_ff))
    else $error("status read data does not carry change flag");

endmodule : odc_top

//--- odc_top_tb.sv
// Self-checking bench for the orientation configuration and debounce block.
`timescale 1ns/10ps
`include "odc_defs.svh"
module odc_top_tb;
  import odc_pkg::*;
  localparam int S [7] = '{4, 8, 16, 32, 64, 128, 256};
  localparam int IX [4][8] = '{'{0, 1, 2, 3, 4, 4, 4, 4}, '{0, 1, 2, 3, 4, 5, 5, 5},
    '{0, 1, 1, 1, 1, 1, 1, 1}, '{0, 1, 2, 3, 4, 5, 6, 6}};
  localparam int ZL [8] = '{14, 18, 21, 25, 29, 33, 37, 42};
  localparam int HS [8] = '{0, 4, 7, 11, 14, 17, 21, 24};
  localparam int TC [10] = '{7, 9, 12, 13, 15, 16, 19, 20, 23, 25};
  localparam int TA [10] = '{15, 20, 30, 35, 40, 45, 55, 60, 70, 75};
  localparam logic [7:0] RV [5] = '{8'h00, 8'h00, 8'h00, 8'h44, 8'h84};
  logic clk, arst_n, act, slp, ovr, yn, xn, wr, rd, flag, b;
  logic [7:0] addr, wdata, rdata, st, d, a;
  logic [2:0] rate;
  logic [1:0] osm;
  logic [8:0] zang;
  logic [6:0] ztilt, plang;
  int fails, total_checks, p, n, seed;

  odc_top #(.STEP_800_CYC(S[0]), .STEP_400_CYC(S[1]), .STEP_200_CYC(S[2]), .STEP_100_CYC(S[3]),
    .STEP_50_CYC(S[4]), .STEP_LOW_CYC(S[5]), .STEP_SLOW_CYC(S[6])) uut (
    .I_CLK_SYS(clk), .I_ARST_N(arst_n), .I_REG_ADDR(addr), .I_REG_WR(wr), .I_REG_WDATA(wdata),
    .I_REG_RD(rd), .O_REG_RDATA(rdata), .I_ACTIVE(act), .I_SLEEP(slp), .I_OUTPUT_SAMPLE_RATE(rate),
    .I_OVERSAMPLING_MODE(osm), .I_Z_ANGLE(zang), .I_Z_TILT(ztilt), .I_PL_ANGLE(plang), .I_Y_NEG(yn),
    .I_X_NEG(xn), .I_OVER_RANGE(ovr), .O_ORIENT_STATUS(st), .O_ORIENT_CHANGE_FLAG(flag));
  odc_host host (.i_clk(clk), .o_addr(addr), .o_wr(wr), .o_wdata(wdata), .o_rd(rd), .i_rdata(rdata));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      $display("[FAIL] %s expected %0h seen %0h", nm, e, g);
      fails++;
    end
  endtask : chk

  task automatic final_report();
    if (fails == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : final_report

  task automatic flip();
    zang = (zang == 9'h000) ? 9'h0B4 : 9'h000;
  endtask : flip

  // Counts falling edges until the back/front bit of the status changes.
  task automatic ew(output int c);
    logic v;
    v = st[0];
    c = 0;
    while (st[0] === v && c < 4000) begin
      @(negedge clk);
      c++;
    end
    if (c >= 4000) chk("timeout", 16'h0000, 16'h0001);
  endtask : ew

  task automatic ap(input string nm, input logic [7:0] m, input logic [7:0] e);
    repeat (3 * p) @(negedge clk);
    chk(nm, {8'h00, e}, {8'h00, st & m});
  endtask : ap

  initial begin
    seed = 32'h9B15;
    fails = 0;
    total_checks = 0;
    arst_n = 1'b0;
    act = 1'b1;
    slp = 1'b0;
    ovr = 1'b0;
    yn = 1'b0;
    xn = 1'b0;
    rate = 3'h0;
    osm = 2'h0;
    zang = 9'h0B4;
    ztilt = 7'h5A;
    plang = 7'h59;
    p = S[0];
    repeat (4) @(negedge clk);
    arst_n = 1'b1;
    for (int i = 0; i < 5; i++) begin
      host.rd(8'(`ODC_ADDR_STATUS + i), d);
      chk("reset value", {8'h00, RV[i]}, {8'h00, d});
    end
    host.wr(`ODC_ADDR_STATUS, 8'hFF);
    host.wr(8'h20, 8'hFF);
    host.rd(8'h20, d);
    chk("unmapped", 16'h0000, {8'h00, d});
    host.rd(`ODC_ADDR_STATUS, d);
    chk("status", 16'h0000, {8'h00, d});
    for (int i = 0; i < 12; i++) begin
      n = $random(seed);
      a = 8'(`ODC_ADDR_CFG + i % 4);
      if (a == `ODC_ADDR_THS) n = (n & 32'h3F) | 32'h40;
      host.wr(a, n[7:0]);
      host.rd(a, d);
      chk("readback", {8'h00, n[7:0]}, {8'h00, d});
    end
    host.wr(`ODC_ADDR_DBNC, 8'h00);
    host.wr(`ODC_ADDR_BFZ, 8'h7C);
    host.wr(`ODC_ADDR_THS, 8'h84);
    host.wr(`ODC_ADDR_CFG, 8'h7F);
    repeat (3 * p) @(negedge clk);
    flip();
    ew(n);
    for (int r = 0; r < 8; r++) begin
      for (int m = 0; m < 4; m++) begin
        rate = 3'(r);
        osm = 2'(m);
        flip();
        ew(n);
        flip();
        ew(n);
        chk("step", 16'(S[IX[m][r]]), 16'(n));
      end
    end
    rate = 3'h4;
    osm = 2'h0;
    p = S[4];
    host.wr(`ODC_ADDR_DBNC, 8'h03);
    flip();
    ew(n);
    flip();
    ew(n);
    chk("count", 16'(4 * p), 16'(n));
    for (int dm = 0; dm < 2; dm++) begin
      host.wr(`ODC_ADDR_CFG, {dm[0], 7'h7F});
      flip();
      ew(n);
      flip();
      repeat (5 * p / 2) @(negedge clk);
      flip();
      repeat (p) @(negedge clk);
      flip();
      ew(n);
      chk("lapse mode", 16'(dm ? 5 * p / 2 : 7 * p / 2), 16'(n));
    end
    for (int s = 0; s < 2; s++) begin
      flip();
      ew(n);
      flip();
      repeat (5 * p / 2) @(negedge clk);
      slp = ~slp;
      ew(n);
      chk("sleep restart", 16'(7 * p / 2), 16'(n));
    end
    b = st[0];
    ovr = 1'b1;
    flip();
    ap("frozen", 8'h01, {7'h00, b});
    ovr = 1'b0;
    ew(n);
    if (st[0]) begin
      flip();
      ew(n);
    end
    host.wr(`ODC_ADDR_CFG, 8'h3F);
    flip();
    ap("disabled", 8'h01, 8'h00);
    host.rd(`ODC_ADDR_STATUS, d);
    host.wr(`ODC_ADDR_CFG, 8'h7F);
    repeat (2 * p) @(negedge clk);
    chk("first flag", 16'h0001, {15'h0000, flag});
    host.rd(`ODC_ADDR_STATUS, d);
    chk("status read", 16'h0081, {8'h00, d & 8'h81});
    chk("flag cleared", 16'h0000, {15'h0000, flag});
    act = 1'b0;
    repeat (2 * p) @(negedge clk);
    act = 1'b1;
    repeat (2 * p) @(negedge clk);
    chk("active flag", 16'h0001, {15'h0000, flag});
    host.wr(`ODC_ADDR_DBNC, 8'h00);
    rate = 3'h0;
    p = S[0];
    for (int k = 0; k < 8; k++) begin
      host.wr(`ODC_ADDR_BFZ, {5'h0F, 3'(k)});
      ztilt = 7'(ZL[k] - 2);
      ap("lockout", 8'h40, 8'h40);
      ztilt = 7'(ZL[k] + 2);
      ap("no lockout", 8'h40, 8'h00);
    end
    ztilt = 7'h5A;
    for (int k = 0; k < 4; k++) begin
      host.wr(`ODC_ADDR_BFZ, {2'(k), 6'h3C});
      zang = 9'(79 - 5 * k);
      ap("back low", 8'h01, 8'h01);
      zang = 9'(101 + 5 * k);
      ap("front low", 8'h01, 8'h00);
      zang = 9'(281 + 5 * k);
      ap("back high", 8'h01, 8'h01);
      zang = 9'(259 - 5 * k);
      ap("front high", 8'h01, 8'h00);
    end
    host.wr(`ODC_ADDR_BFZ, 8'h44);
    for (int h = 0; h < 8; h++) begin
      host.wr(`ODC_ADDR_THS, {5'h10, 3'(h)});
      yn = 1'($random(seed));
      xn = 1'($random(seed));
      plang = 7'(46 - HS[h]);
      ap("hold portrait", 8'h06, {6'h00, yn, 1'b0});
      plang = 7'(43 - HS[h]);
      ap("to landscape", 8'h06, {5'h01, xn, 1'b0});
      plang = 7'(44 + HS[h]);
      ap("hold landscape", 8'h06, {5'h01, xn, 1'b0});
      plang = 7'(47 + HS[h]);
      ap("to portrait", 8'h06, {6'h00, yn, 1'b0});
    end
    for (int t = 0; t < 10; t++) begin
      host.wr(`ODC_ADDR_THS, {5'(TC[t]), 3'h0});
      plang = 7'(TA[t] + 3);
      ap("above trip", 8'h04, 8'h00);
      plang = 7'(TA[t] - 3);
      ap("below trip", 8'h04, 8'h04);
    end
    final_report();
  end

  // The whole sequence needs well under a fifth of this span.
  initial begin
    #400000;
    fails++;
    final_report();
  end
endmodule : odc_top_tb
